/* File: logic/anhp_pkg.sv */
package anhp_pkg;
  // ==========================================
  // Commands on the low byte lanes
  localparam logic [7:0] CMD_READ1 = 8'h00;
  localparam logic [7:0] CMD_READ2 = 8'h30;
  localparam logic [7:0] CMD_WRITE1 = 8'h80;
  localparam logic [7:0] CMD_WRITE2 = 8'h10;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_PARAM = 8'hEC;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] ID_ADDR_MFR = 8'h00;
  localparam logic [7:0] ID_ADDR_SIG = 8'h20;
  localparam int ADDR_BYTES = 5;
  localparam int ADDR_BITS_X8 = 21;
  localparam int STATUS_RDY_BIT = 6;
  // ==========================================
  // Controller register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_RDATA = 4'h3;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_CFG = 4'h5;
  // CTRL field positions
  localparam int CTRL_CMD_LSB = 0;
  localparam int CTRL_OP_LSB = 8;
  // Operation codes written to CTRL[10:8]
  localparam logic [2:0] OP_CMD = 3'h1;
  localparam logic [2:0] OP_CMD_ADDR5 = 3'h2;
  localparam logic [2:0] OP_CMD_ADDR1 = 3'h3;
  localparam logic [2:0] OP_WDATA = 3'h4;
  localparam logic [2:0] OP_RDATA = 3'h5;
  localparam logic [2:0] OP_CMD_ADDR5_CMD = 3'h6;
  // STAT bits
  localparam int STAT_BUSY = 0;
  localparam int STAT_RB = 1;
  localparam int STAT_ERR = 2;
  localparam logic [3:0] CFG_RESET = 4'h2;
  // ==========================================
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int T_STROBE_NS = 30;
  localparam int T_WHR_NS = 120;
  localparam int STROBE_CYC = (T_STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int WHR_CYC = (T_WHR_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic wp_n;
  } anhp_ctl_t;
endpackage

/* File: logic/anhp_host.sv */
// ==========================================
module anhp_host #(
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output anhp_pkg::anhp_ctl_t nand_ctl,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic [DATA_W-1:0] dq_i,
  input wire logic rb_i,
  output logic hardware_save_strobe_n
);
  initial begin
    if (DATA_W != 8 && DATA_W != 16) begin
      $error("DATA_W must be 8 or 16");
    end
  end

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_CMD = 7'b0000010,
    ST_ADDR = 7'b0000100,
    ST_CMD2 = 7'b0001000,
    ST_WDAT = 7'b0010000,
    ST_RDAT = 7'b0100000,
    ST_WAIT = 7'b1000000
  } anhp_st_t;

  // ==========================================
  // Ready/busy synchroniser: three stages, change once stages two and three agree
  logic rb_s1_r, rb_s2_r, rb_s3_r, rb_r;
  logic rb_nxt;
  always_comb begin
    rb_nxt = rb_r;
    if (rb_s2_r == rb_s3_r) begin
      rb_nxt = rb_s3_r;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rb_s1_r <= 1'b0;
      rb_s2_r <= 1'b0;
      rb_s3_r <= 1'b0;
      rb_r <= 1'b0;
    end else begin
      rb_s1_r <= rb_i;
      rb_s2_r <= rb_s1_r;
      rb_s3_r <= rb_s2_r;
      rb_r <= rb_nxt;
    end
  end

  // ==========================================
  // Sequencer
  anhp_st_t st_r, st_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [2:0] op_r, op_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [15:0] wdat_r, wdat_nxt;
  logic [15:0] rdat_r, rdat_nxt;
  logic [3:0] cfg_r, cfg_nxt;
  logic err_r, err_nxt;
  logic [2:0] abyte_r, abyte_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic ph_r, ph_nxt;
  anhp_pkg::anhp_ctl_t ctl_r, ctl_nxt;
  logic [DATA_W-1:0] dqo_r, dqo_nxt;
  logic oe_r, oe_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic busy;
  logic allowed;
  logic [7:0] abyte_val;
  logic [7:0] wcmd;
  logic [2:0] wop;

  assign busy = (st_r != ST_IDLE);
  assign wcmd = reg_wdata[anhp_pkg::CTRL_CMD_LSB +: 8];
  assign wop = reg_wdata[anhp_pkg::CTRL_OP_LSB +: 3];
  // Only status and reset go out while the device shows busy
  assign allowed = rb_r || wcmd == anhp_pkg::CMD_STATUS
                   || wcmd == anhp_pkg::CMD_RESET;

  always_comb begin
    abyte_val = 8'h00;
    case (abyte_r)
      3'd0: abyte_val = addr_r[7:0];
      3'd1: abyte_val = addr_r[15:8];
      3'd2: begin
        abyte_val = {3'b000, addr_r[20:16]};
        if (cfg_r[0]) begin
          abyte_val[4] = 1'b0;
        end
      end
      default: abyte_val = 8'h00;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    cmd_nxt = cmd_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    rdat_nxt = rdat_r;
    cfg_nxt = cfg_r;
    err_nxt = err_r;
    abyte_nxt = abyte_r;
    cnt_nxt = cnt_r;
    ph_nxt = ph_r;
    ctl_nxt = ctl_r;
    dqo_nxt = dqo_r;
    oe_nxt = oe_r;
    rd_nxt = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        anhp_pkg::REG_CTRL: rd_nxt = {21'h0, op_r, cmd_r};
        anhp_pkg::REG_ADDR: rd_nxt = {8'h00, addr_r};
        anhp_pkg::REG_WDATA: rd_nxt = {16'h0000, wdat_r};
        anhp_pkg::REG_RDATA: rd_nxt = {16'h0000, rdat_r};
        anhp_pkg::REG_STAT: rd_nxt = {29'h0, err_r, rb_r, busy};
        anhp_pkg::REG_CFG: rd_nxt = {28'h0, cfg_r};
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
    if (reg_wr) begin
      case (reg_addr)
        anhp_pkg::REG_ADDR: addr_nxt = reg_wdata[23:0];
        anhp_pkg::REG_WDATA: wdat_nxt = reg_wdata[15:0];
        anhp_pkg::REG_CFG: cfg_nxt = reg_wdata[3:0];
        anhp_pkg::REG_CTRL: begin
          if (!busy) begin
            if (allowed) begin
              cmd_nxt = wcmd;
              op_nxt = wop;
              err_nxt = 1'b0;
              ph_nxt = 1'b0;
              cnt_nxt = 8'h00;
              abyte_nxt = 3'd0;
              st_nxt = (wop == anhp_pkg::OP_WDATA) ? ST_WDAT
                     : (wop == anhp_pkg::OP_RDATA) ? ST_RDAT : ST_CMD;
            end else begin
              err_nxt = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end
    // Each phase holds STROBE_CYC+1 cycles; ph_r=0 strobe low, 1 strobe high
    case (st_r)
      ST_IDLE: begin
        ctl_nxt.ce_n = ~cfg_r[1];
        ctl_nxt.cle = 1'b0;
        ctl_nxt.ale = 1'b0;
        ctl_nxt.we_n = 1'b1;
        ctl_nxt.re_n = 1'b1;
        oe_nxt = 1'b0;
      end
      ST_CMD, ST_CMD2, ST_ADDR, ST_WDAT: begin
        ctl_nxt.ce_n = 1'b0;
        ctl_nxt.re_n = 1'b1;
        ctl_nxt.cle = (st_r == ST_CMD || st_r == ST_CMD2);
        ctl_nxt.ale = (st_r == ST_ADDR);
        oe_nxt = 1'b1;
        dqo_nxt = '0;
        if (st_r == ST_CMD) begin
          dqo_nxt[7:0] = cmd_r;
        end else if (st_r == ST_CMD2) begin
          dqo_nxt[7:0] = anhp_pkg::CMD_READ2;
        end else if (st_r == ST_ADDR) begin
          dqo_nxt[7:0] = abyte_val;
        end else begin
          dqo_nxt = wdat_r[DATA_W-1:0];
        end
        ctl_nxt.we_n = ph_r;
        cnt_nxt = cnt_r + 8'd1;
        if (cnt_r == 8'(anhp_pkg::STROBE_CYC)) begin
          cnt_nxt = 8'h00;
          ph_nxt = ~ph_r;
          if (ph_r) begin
            // Rising edge of WE happened; choose the next phase
            if (st_r == ST_CMD) begin
              if (op_r == anhp_pkg::OP_CMD_ADDR5 || op_r == anhp_pkg::OP_CMD_ADDR1
                  || op_r == anhp_pkg::OP_CMD_ADDR5_CMD) begin
                st_nxt = ST_ADDR;
              end else if (cmd_r == anhp_pkg::CMD_RESET) begin
                st_nxt = ST_WAIT;
              end else begin
                st_nxt = ST_IDLE;
              end
            end else if (st_r == ST_ADDR) begin
              abyte_nxt = abyte_r + 3'd1;
              if (op_r == anhp_pkg::OP_CMD_ADDR1
                  || abyte_r == 3'(anhp_pkg::ADDR_BYTES - 1)) begin
                // ID and page reads need the write-to-read wait
                st_nxt = (op_r == anhp_pkg::OP_CMD_ADDR5_CMD) ? ST_CMD2 : ST_WAIT;
              end
            end else if (st_r == ST_CMD2) begin
              st_nxt = ST_WAIT;
            end else begin
              st_nxt = ST_IDLE;
            end
          end
        end
      end
      ST_RDAT: begin
        ctl_nxt.ce_n = 1'b0;
        ctl_nxt.cle = 1'b0;
        ctl_nxt.ale = 1'b0;
        ctl_nxt.we_n = 1'b1;
        oe_nxt = 1'b0;
        ctl_nxt.re_n = ph_r;
        cnt_nxt = cnt_r + 8'd1;
        if (cnt_r == 8'(anhp_pkg::STROBE_CYC)) begin
          cnt_nxt = 8'h00;
          ph_nxt = ~ph_r;
          if (!ph_r) begin
            rdat_nxt = '0;
            rdat_nxt[DATA_W-1:0] = dq_i;
          end else begin
            st_nxt = ST_IDLE;
          end
        end
      end
      ST_WAIT: begin
        ctl_nxt.we_n = 1'b1;
        ctl_nxt.cle = 1'b0;
        ctl_nxt.ale = 1'b0;
        oe_nxt = 1'b0;
        cnt_nxt = cnt_r + 8'd1;
        // Ends after the write-to-read wait once the device shows ready
        if (cnt_r >= 8'(anhp_pkg::WHR_CYC) && rb_r) begin
          cnt_nxt = 8'h00;
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ST_IDLE;
      cmd_r <= 8'h00;
      op_r <= 3'h0;
      addr_r <= 24'h00_0000;
      wdat_r <= 16'h0000;
      rdat_r <= 16'h0000;
      cfg_r <= anhp_pkg::CFG_RESET;
      err_r <= 1'b0;
      abyte_r <= 3'h0;
      cnt_r <= 8'h00;
      ph_r <= 1'b0;
      ctl_r <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0};
      dqo_r <= '0;
      oe_r <= 1'b0;
      rd_r <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
      cmd_r <= cmd_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      rdat_r <= rdat_nxt;
      cfg_r <= cfg_nxt;
      err_r <= err_nxt;
      abyte_r <= abyte_nxt;
      cnt_r <= cnt_nxt;
      ph_r <= ph_nxt;
      ctl_r <= ctl_nxt;
      dqo_r <= dqo_nxt;
      oe_r <= oe_nxt;
      rd_r <= rd_nxt;
    end
  end

  // Write protect follows CFG bit 2: low keeps the array safe
  always_comb begin
    nand_ctl = ctl_r;
    nand_ctl.wp_n = cfg_r[2];
  end
  assign dq_o = dqo_r;
  assign dq_oe = oe_r;
  assign reg_rdata = rd_r;
  assign hardware_save_strobe_n = ~cfg_r[3];
endmodule

/* File: verif/anhp_host_monitor.sv */
module anhp_host_chk #(
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire anhp_pkg::anhp_ctl_t nand_ctl,
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic dq_oe,
  input wire logic [DATA_W-1:0] dq_i,
  input wire logic rb_i,
  input wire logic hardware_save_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic we_q_r;
  logic [2:0] acnt_r;
  logic [2:0] acnt_nxt;
  logic we_rise;
  assign we_rise = nand_ctl.we_n && !we_q_r;
  // ==========================================
  // Address cycles seen in the current latch window
  always_comb begin
    acnt_nxt = acnt_r;
    if (!nand_ctl.ale) begin
      acnt_nxt = 3'h0;
    end else if (we_rise) begin
      acnt_nxt = acnt_r + 3'h1;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      we_q_r <= 1'b1;
      acnt_r <= 3'h0;
    end else begin
      we_q_r <= nand_ctl.we_n;
      acnt_r <= acnt_nxt;
    end
  end
  sequence we_hold_s;
    (!nand_ctl.we_n && $stable(dq_o) && dq_oe)[*2] ##1 nand_ctl.we_n;
  endsequence
  sequence re_hold_s;
    (!nand_ctl.re_n && !dq_oe)[*2] ##1 nand_ctl.re_n;
  endsequence
  cmd_hold_a: assert property ($fell(nand_ctl.we_n) && nand_ctl.cle |-> ##1 we_hold_s)
    else $error("command byte not held");
  addr_hold_a: assert property ($fell(nand_ctl.we_n) && nand_ctl.ale |-> ##1 we_hold_s)
    else $error("address byte not held");
  read_phase_a: assert property ($fell(nand_ctl.re_n) |-> !nand_ctl.ale ##1 re_hold_s)
    else $error("read phase malformed");
  strobe_excl_a: assert property (nand_ctl.we_n || nand_ctl.re_n)
    else $error("both strobes low");
  latch_excl_a: assert property (!(nand_ctl.cle && nand_ctl.ale))
    else $error("command and address latch both high");
  deselect_a: assert property (nand_ctl.ce_n |-> nand_ctl.we_n && nand_ctl.re_n)
    else $error("strobe while deselected");
  addr_count_a: assert property ($fell(nand_ctl.ale) |-> acnt_r == 3'h1 || acnt_r == 3'h5)
    else $error("wrong address cycle count");
  addr_zero_a: assert property (we_rise && nand_ctl.ale && acnt_r > 3'h2 |-> dq_o[7:0] == 8'h00)
    else $error("upper address byte not zero");
  addr_top_a: assert property (we_rise && nand_ctl.ale && acnt_r == 3'h2 |-> dq_o[7:5] == 3'h0)
    else $error("third address byte top bits set");
  busy_cmd_a: assert property (we_rise && nand_ctl.cle && !rb_i |-> dq_o[7:0] inside {8'h70, 8'hFF})
    else $error("command sent while busy");
endmodule
bind anhp_host anhp_host_chk #(.DATA_W(DATA_W)) u_anhp_host_chk (
  .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nand_ctl(nand_ctl), .dq_o(dq_o), .dq_oe(dq_oe),
  .dq_i(dq_i), .rb_i(rb_i), .hardware_save_strobe_n(hardware_save_strobe_n)
);

/* File: verif/anhp_dev_model.sv */
module anhp_dev_model #(
  parameter int BUSY_NS = 2000,
  // Arbitrary identity word, maker code then part code
  parameter logic [31:0] ID_WORD = 32'h5A3C_C3A5
) (
  input wire anhp_pkg::anhp_ctl_t ctl,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe,
  output logic [15:0] dq_i,
  output logic rb_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [16];
  logic [7:0] cmd = 8'h00;
  logic [7:0] out = 8'h00;
  logic [23:0] adr = 24'h0;
  logic [3:0] off = 4'h0;
  int acnt = 0;
  logic busy = 1'b0;
  logic drv = 1'b0;
  // Released lines show a changed value, never the last one
  logic [15:0] flt = 16'h5A5A;
  initial foreach (mem[i]) mem[i] = 8'hEE;
  assign rb_i = busy ? 1'b0 : 1'b1;
  assign dq_i = dq_oe ? dq_o : drv ? {~out, out} : flt;
  always @(negedge dq_oe) flt = ~dq_o;
  // ==========================================
  // Strobe-edge decoding: commands, addresses and data latched on write strobe rise, read data driven on read strobe fall
  always @(posedge ctl.we_n) if (!ctl.ce_n && ctl.re_n) begin
    if (ctl.cle && !ctl.ale) begin
      if (!busy || dq_o[7:0] == 8'h70 || dq_o[7:0] == 8'hFF) begin
        cmd = (dq_o[7:0] == 8'hFF) ? 8'h00 : dq_o[7:0];
        off = 4'h0;
        acnt = 0;
        if (cmd == 8'hFC) fork begin #100; busy = 1'b1; #(BUSY_NS); busy = 1'b0; end join_none
      end
    end else if (!busy && ctl.ale && !ctl.cle) begin
      if (acnt < 3) adr[8*acnt +: 8] = dq_o[7:0];
      acnt = acnt + 1;
      off = 4'h0;
    end else if (!busy && !ctl.ale && !ctl.cle && cmd == 8'h80) begin
      if (ctl.wp_n) mem[adr[3:0] + off] = dq_o[7:0];
      off = off + 4'h1;
    end
  end
  always @(negedge ctl.re_n) begin
    if (!ctl.ce_n && !ctl.ale && !ctl.cle && ctl.we_n && (!busy || cmd == 8'h70)) begin
      case (cmd)
        8'h30: out = mem[adr[3:0] + off];
        8'h90: out = 8'((adr[7:0] == 8'h20 ? 32'h4F4E4649 : ID_WORD) >> (8 * (3 - off)));
        8'hEC: out = off < 4 ? 8'(32'h4F4E4649 >> (8 * (3 - off))) : (off == 4 ? 8'h02 : 8'h00);
        8'h70: out = {ctl.wp_n, !busy, 6'h00};
        default: out = 8'h00;
      endcase
      drv = 1'b1;
      off = off + 4'h1;
    end
  end
  always @(posedge ctl.re_n or posedge ctl.ce_n) if (drv) begin
    drv = 1'b0;
    flt = {out, ~out};
  end
endmodule

/* File: verif/async_nand_host_port_tb_top.sv */
module async_nand_host_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary identity word
  localparam logic [31:0] ID_WORD = 32'h5A3C_C3A5;
  typedef struct packed {
    logic [7:0] cmd;
    logic [2:0] op;
    logic [7:0] adr;
    logic [3:0] n;
    logic [63:0] exp;
  } anhp_row_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  anhp_pkg::anhp_ctl_t nand_ctl;
  logic [15:0] dq_o;
  logic [15:0] dq_i;
  logic dq_oe;
  logic rb_i;
  logic save_n;
  int checks = 0;
  int miscompares = 0;
  anhp_row_t rows [4];
  always #10 clk = ~clk;
  anhp_host #(.DATA_W(16)) u_anhp_host (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .nand_ctl(nand_ctl), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .rb_i(rb_i),
    .hardware_save_strobe_n(save_n));
  anhp_dev_model #(.ID_WORD(ID_WORD)) u_anhp_dev_model (.ctl(nand_ctl), .dq_o(dq_o),
    .dq_oe(dq_oe), .dq_i(dq_i), .rb_i(rb_i));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk) begin reg_addr <= a; reg_rd <= 1'b1; end
    @(posedge clk) reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Start an operation, then poll until the controller is no longer busy
  task automatic op(input logic [7:0] c, input logic [2:0] o);
    logic [31:0] v;
    int i;
    wr(anhp_pkg::REG_CTRL, {21'h0, o, c});
    for (i = 0; i < 300; i++) begin
      rd(anhp_pkg::REG_STAT, v);
      if (v[0] === 1'b0) break;
    end
    if (i == 300) begin
      miscompares++;
      wrap_up();
    end
  endtask
  task automatic rdb(input int n, input logic [63:0] e);
    logic [31:0] v;
    for (int i = 0; i < n; i++) begin
      op(8'h70, anhp_pkg::OP_RDATA);
      rd(anhp_pkg::REG_RDATA, v);
      chk({24'h0, v[7:0]}, {24'h0, e[63-8*i -: 8]});
    end
  endtask
  task automatic wd(input logic [7:0] d);
    wr(anhp_pkg::REG_WDATA, {24'h0, d});
    op(8'h70, anhp_pkg::OP_WDATA);
  endtask
  initial begin
    logic [31:0] v;
    rows[0] = '{8'h90, anhp_pkg::OP_CMD_ADDR1, 8'h20, 4'h4, 64'h4F4E4649_00000000};
    rows[1] = '{8'h90, anhp_pkg::OP_CMD_ADDR1, 8'h00, 4'h4, {ID_WORD, 32'h0}};
    rows[2] = '{8'hEC, anhp_pkg::OP_CMD_ADDR1, 8'h00, 4'h8, 64'h4F4E4649_02000000};
    rows[3] = '{8'h70, anhp_pkg::OP_CMD, 8'h00, 4'h1, 64'hC000_0000_0000_0000};
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    rd(anhp_pkg::REG_CFG, v);
    chk(v, 32'h2);
    chk({31'h0, save_n}, 32'h1);
    rd(4'hF, v);
    chk(v, 32'h0);
    repeat (4) @(posedge clk);
    rd(anhp_pkg::REG_STAT, v);
    chk(v, 32'h2);
    wr(anhp_pkg::REG_CFG, 32'h6);
    foreach (rows[k]) begin
      wr(anhp_pkg::REG_ADDR, {24'h0, rows[k].adr});
      op(rows[k].cmd, rows[k].op);
      rdb(rows[k].n, rows[k].exp);
    end
    wr(anhp_pkg::REG_ADDR, 32'h5);
    op(8'h80, anhp_pkg::OP_CMD_ADDR5);
    wd(8'hA5);
    wd(8'h3C);
    op(8'h00, anhp_pkg::OP_CMD_ADDR5_CMD);
    rdb(2, 64'hA53C_0000_0000_0000);
    // Protected write must leave the cell alone
    wr(anhp_pkg::REG_CFG, 32'h2);
    wr(anhp_pkg::REG_ADDR, 32'h7);
    op(8'h80, anhp_pkg::OP_CMD_ADDR5);
    wd(8'h77);
    wr(anhp_pkg::REG_CFG, 32'h6);
    op(8'h00, anhp_pkg::OP_CMD_ADDR5_CMD);
    rdb(1, 64'hEE00_0000_0000_0000);
    // Reset in mid-write drops the open write
    wr(anhp_pkg::REG_ADDR, 32'h9);
    op(8'h80, anhp_pkg::OP_CMD_ADDR5);
    op(8'hFF, anhp_pkg::OP_CMD);
    wd(8'h55);
    op(8'h00, anhp_pkg::OP_CMD_ADDR5_CMD);
    rdb(1, 64'hEE00_0000_0000_0000);
    op(8'hFC, anhp_pkg::OP_CMD);
    repeat (10) @(posedge clk);
    op(8'h00, anhp_pkg::OP_CMD);
    rd(anhp_pkg::REG_STAT, v);
    chk(v, 32'h4);
    op(8'h70, anhp_pkg::OP_CMD);
    rdb(1, 64'h8000_0000_0000_0000);
    repeat (120) @(posedge clk);
    op(8'h70, anhp_pkg::OP_CMD);
    rdb(1, 64'hC000_0000_0000_0000);
    // Deselect with the save strobe pulled, then reset in mid-run
    wr(anhp_pkg::REG_CFG, 32'h8);
    repeat (2) @(posedge clk);
    #1 chk({30'h0, nand_ctl.ce_n, save_n}, 32'h2);
    @(posedge clk) arst_n <= 1'b0;
    @(posedge clk) arst_n <= 1'b1;
    #1 chk({30'h0, nand_ctl.ce_n, save_n}, 32'h3);
    rd(anhp_pkg::REG_CFG, v);
    chk(v, 32'h2);
    rd(anhp_pkg::REG_STAT, v);
    chk(v, 32'h0);
    rd(anhp_pkg::REG_STAT, v);
    chk(v, 32'h2);
    wrap_up();
  end
endmodule
